/* File: common/link_tester_cfg.svh */
/*
  Constants of the repeat-reset link tester: register offsets, field
  positions, response codes and timing counts.
  Assumes a 40 MHz clock and word-aligned AXI4-Lite byte addresses.
*/
// Operation
// - Sequencer has idle, hold, release, wait, second wait, check, fail, done.
// - Idle keeps pass flag and fail flag at zero, and the iteration timer too while start is low.
// - Start enters hold and drives physical init for a 28-bit counted period.
// - Release drops physical init and preloads window from 3-bit select.
// - Wait until window expires; data or soft errors fail; ready stable.
// - Failed wait stops the run; otherwise go to second wait.
// - Check rechecks ready transitions; at most one returns to idle, or to done at the target count.
// - Pass flag rises when all selected iterations complete successfully.
// - Fail flag rises on missing channel ready or data errors.
// - A 4-bit select chooses a fixed iteration count per code.
// - Sequencer clear returns the sequencer to its initial condition.
// - Quality clear zeroes every link quality counter.
// - Twenty-bit channel ready transition count; bits 15 to 8 exposed.
// - Twenty-bit count of link restart requests, exposed for monitoring.
`ifndef LINK_TESTER_CFG_SVH
`define LINK_TESTER_CFG_SVH

`define CLK_MHZ 40
`define HOLD_CYCLES_DEF 28'hfffffff
`define WINDOW_UNIT_MS 100
`define WINDOW_UNIT_CYCLES_DEF (`WINDOW_UNIT_MS * `CLK_MHZ * 1000)
`define SECOND_WAIT_US 50
`define SECOND_WAIT_CYCLES 32'(`SECOND_WAIT_US * `CLK_MHZ)
`define ITER_STEP 16'h000a

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define READY_COUNT_OFFSET 8'h08
`define RESTART_COUNT_OFFSET 8'h0c
`define INT_STATUS_OFFSET 8'h10
`define INT_MASK_OFFSET 8'h14

`define CTRL_START 0
`define CTRL_SEQ_CLEAR 1
`define CTRL_QUAL_CLEAR 2
`define CTRL_WIN_LSB 4
`define CTRL_ITER_LSB 8

`define INT_PASS 0
`define INT_FAIL 1
`define INT_RESTART 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: common/link_tester_pkg.sv */
/*
  Types of the repeat-reset link tester.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package link_tester_pkg;
  typedef enum logic [2:0] {
    idle_state,
    hold_init_state,
    release_init_state,
    wait_state,
    second_wait_state,
    check_state,
    fail_state,
    done_state
  } seq_state_t;
endpackage : link_tester_pkg

/* File: core/repeat_reset_link_tester.sv */
/*
  Repeat-reset link tester: resets a serial link core over and over and
  checks how the link recovers, with an AXI4-Lite register slave and a
  level interrupt.
  Assumes all link inputs are synchronous to aclk and one write and one
  read at most are under way on the bus.
*/
// Implementation choices: the AXI4-Lite register port and the register addresses.
`include "link_tester_cfg.svh"

module repeat_reset_link_tester
  import link_tester_pkg::*;
#(
  parameter logic [27:0] HOLD_CYCLES = `HOLD_CYCLES_DEF,
  parameter logic [31:0] WINDOW_UNIT_CYCLES = 32'(`WINDOW_UNIT_CYCLES_DEF)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic channel_ready,
  input wire logic soft_error,
  input wire logic link_restart_request,
  input wire logic [7:0] data_mismatch_count,
  output logic transceiver_phys_init,
  output logic irq
);

  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_en;
  logic repeat_test_start;
  logic test_sequencer_clear;
  logic quality_counter_clear;
  logic [2:0] check_window_select;
  logic [3:0] iteration_count_select;
  seq_state_t state;
  logic test_pass_flag;
  logic test_fail_flag;
  logic [15:0] iter_timer;
  logic [27:0] hold_cnt;
  logic [31:0] window_timer;
  logic [1:0] iter_toggles;
  logic ready_d;
  logic restart_d;
  logic ready_toggle;
  logic data_error;
  logic [15:0] iter_target;
  logic [31:0] window_cycles;
  logic [19:0] ready_transition_count;
  logic [19:0] link_restart_count;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [2:0] int_event;

  // Write address and data are both held and no response is pending.
  assign wr_en = !awready && !wready && !bvalid;
  assign ready_toggle = channel_ready ^ ready_d;
  assign data_error = data_mismatch_count != 8'h00;
  assign iter_target = (16'(iteration_count_select) + 16'h0001) * `ITER_STEP;
  assign window_cycles = 32'((32'(check_window_select) + 32'h00000001) * WINDOW_UNIT_CYCLES);

  // Write address channel: take once, reopen after the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awaddr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // Write data channel, independent of the address so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Write response one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      case (awaddr_q)
        `CTRL_OFFSET, `STATUS_OFFSET, `READY_COUNT_OFFSET, `RESTART_COUNT_OFFSET,
        `INT_STATUS_OFFSET, `INT_MASK_OFFSET: bresp <= `RESP_OKAY;
        default: bresp <= `RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control register; the two clear bits are one-cycle pulses, never stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repeat_test_start <= 1'b0;
      test_sequencer_clear <= 1'b0;
      quality_counter_clear <= 1'b0;
      check_window_select <= 3'h0;
      iteration_count_select <= 4'h0;
    end else begin
      test_sequencer_clear <= 1'b0;
      quality_counter_clear <= 1'b0;
      if (wr_en && awaddr_q == `CTRL_OFFSET) begin
        if (wstrb_q[0]) begin
          repeat_test_start <= wdata_q[`CTRL_START];
          test_sequencer_clear <= wdata_q[`CTRL_SEQ_CLEAR];
          quality_counter_clear <= wdata_q[`CTRL_QUAL_CLEAR];
          check_window_select <= wdata_q[`CTRL_WIN_LSB +: 3];
        end
        if (wstrb_q[1]) begin
          iteration_count_select <= wdata_q[`CTRL_ITER_LSB +: 4];
        end
      end
    end
  end

  // Read channel: data is latched at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `CTRL_OFFSET: rdata <= {20'h00000, iteration_count_select, 1'b0, check_window_select, 4'h0};
        `STATUS_OFFSET: rdata <= {iter_timer, ready_transition_count[15:8], 5'h00,
                                  transceiver_phys_init, test_fail_flag, test_pass_flag};
        `READY_COUNT_OFFSET: rdata <= {12'h000, ready_transition_count};
        `RESTART_COUNT_OFFSET: rdata <= {12'h000, link_restart_count};
        `INT_STATUS_OFFSET: rdata <= {29'h00000000, int_status};
        `INT_MASK_OFFSET: rdata <= {29'h00000000, int_mask};
        default: begin
          rdata <= 32'h00000000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Previous levels of channel ready and the link restart request for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_d <= 1'b0;
      restart_d <= 1'b0;
    end else begin
      ready_d <= channel_ready;
      restart_d <= link_restart_request;
    end
  end

  // Sequencer. A clear pulse wins over everything so a stuck run can be restarted.
  always_ff @(posedge aclk) begin
    if (!aresetn || test_sequencer_clear) begin
      state <= idle_state;
      test_pass_flag <= 1'b0;
      test_fail_flag <= 1'b0;
      iter_timer <= 16'h0000;
      hold_cnt <= 28'h0000000;
      window_timer <= 32'h00000000;
      transceiver_phys_init <= 1'b0;
      iter_toggles <= 2'h0;
    end else begin
      // Saturating count of ready changes seen in this iteration.
      if (ready_toggle && iter_toggles != 2'h3) begin
        iter_toggles <= iter_toggles + 2'h1;
      end
      case (state)
        idle_state: begin
          test_pass_flag <= 1'b0;
          test_fail_flag <= 1'b0;
          if (!repeat_test_start) begin
            iter_timer <= 16'h0000;
          end else begin
            state <= hold_init_state;
            hold_cnt <= HOLD_CYCLES;
            transceiver_phys_init <= 1'b1;
          end
        end
        hold_init_state: begin
          if (hold_cnt == 28'h0000000) begin
            state <= release_init_state;
          end else begin
            hold_cnt <= hold_cnt - 28'h0000001;
          end
        end
        release_init_state: begin
          transceiver_phys_init <= 1'b0;
          window_timer <= window_cycles;
          iter_toggles <= 2'h0;
          state <= wait_state;
        end
        wait_state: begin
          // errors abort the window at once.
          if (data_error || soft_error) begin
            state <= fail_state;
          end else if (window_timer == 32'h00000000) begin
            if (channel_ready && iter_toggles <= 2'h1) begin
              state <= second_wait_state;
              window_timer <= `SECOND_WAIT_CYCLES;
            end else begin
              state <= fail_state;
            end
          end else begin
            window_timer <= window_timer - 32'h00000001;
          end
        end
        second_wait_state: begin
          // Packets flow here; the check state judges the result.
          if (window_timer == 32'h00000000) begin
            state <= check_state;
          end else begin
            window_timer <= window_timer - 32'h00000001;
          end
        end
        check_state: begin
          if (iter_toggles > 2'h1 || data_error || !channel_ready) begin
            state <= fail_state;
          end else begin
            iter_timer <= iter_timer + 16'h0001;
            if (iter_timer + 16'h0001 == iter_target) begin
              state <= done_state;
            end else begin
              state <= idle_state;
            end
          end
        end
        fail_state: begin
          test_fail_flag <= 1'b1;
        end
        done_state: begin
          test_pass_flag <= 1'b1;
        end
        default: state <= idle_state;
      endcase
    end
  end

  // Quality counters wrap; they keep running across sequencer clears.
  always_ff @(posedge aclk) begin
    if (!aresetn || quality_counter_clear) begin
      ready_transition_count <= 20'h00000;
      link_restart_count <= 20'h00000;
    end else begin
      if (ready_toggle) begin
        ready_transition_count <= ready_transition_count + 20'h00001;
      end
      if (link_restart_request && !restart_d) begin
        link_restart_count <= link_restart_count + 20'h00001;
      end
    end
  end

  // Events fire on the first cycle in done or fail and on each restart.
  always_comb begin
    int_event = 3'h0;
    int_event[`INT_PASS] = state == done_state && !test_pass_flag;
    int_event[`INT_FAIL] = state == fail_state && !test_fail_flag;
    int_event[`INT_RESTART] = link_restart_request && !restart_d;
  end

  // Sticky status, write one to clear; a new event beats a clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= 3'h0;
    end else if (wr_en && awaddr_q == `INT_STATUS_OFFSET && wstrb_q[0]) begin
      int_status <= (int_status & ~wdata_q[2:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  // Mask register and registered interrupt output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_en && awaddr_q == `INT_MASK_OFFSET && wstrb_q[0]) begin
        int_mask <= wdata_q[2:0];
      end
      irq <= |(int_status & int_mask);
    end
  end

  property p_idle_flags;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == idle_state |=> !test_pass_flag && !test_fail_flag;
  endproperty
  a_idle_flags: assert property (p_idle_flags)
    else $error("Pass or fail flag set after idle.");

  property p_init_rise;
    @(posedge aclk) disable iff (!aresetn)
    $rose(transceiver_phys_init) |-> state == hold_init_state && hold_cnt == HOLD_CYCLES;
  endproperty
  a_init_rise: assert property (p_init_rise)
    else $error("Physical init rose outside the hold state.");

  property p_release;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == release_init_state |=> !transceiver_phys_init && state == wait_state
      && window_timer == $past(window_cycles);
  endproperty
  a_release: assert property (p_release)
    else $error("Release did not drop init and preload the window.");

  property p_wait_error;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == wait_state && (data_error || soft_error) |=> state == fail_state ##1 test_fail_flag;
  endproperty
  a_wait_error: assert property (p_wait_error)
    else $error("Error in wait window did not lead to fail.");

  property p_window_count;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == wait_state && !data_error && !soft_error && window_timer != 32'h00000000
      |=> window_timer == $past(window_timer) - 32'h00000001;
  endproperty
  a_window_count: assert property (p_window_count)
    else $error("Window timer did not step down by one.");

  property p_check_pass;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == check_state && iter_toggles <= 2'h1 && !data_error && channel_ready
      |=> iter_timer == $past(iter_timer) + 16'h0001 && (state == idle_state || state == done_state);
  endproperty
  a_check_pass: assert property (p_check_pass)
    else $error("Good check did not count and return.");

  property p_done_pass;
    @(posedge aclk) disable iff (!aresetn || test_sequencer_clear)
    state == done_state |=> test_pass_flag && iter_timer == iter_target;
  endproperty
  a_done_pass: assert property (p_done_pass)
    else $error("Done without pass flag at target count.");

  property p_restart_count;
    @(posedge aclk) disable iff (!aresetn || quality_counter_clear)
    $rose(link_restart_request) |=> link_restart_count == $past(link_restart_count) + 20'h00001;
  endproperty
  a_restart_count: assert property (p_restart_count)
    else $error("Restart request not counted.");

  property p_qual_clear;
    @(posedge aclk) disable iff (!aresetn)
    quality_counter_clear |=> ready_transition_count == 20'h00000 && link_restart_count == 20'h00000;
  endproperty
  a_qual_clear: assert property (p_qual_clear)
    else $error("Quality counters not cleared.");

endmodule : repeat_reset_link_tester

/* File: tb/link_core_model.sv */
/*
  Behavioural model of the serial link core and its frame checker, as seen
  by the repeat-reset link tester.
  Assumes it shares aclk and aresetn with the tester; the bench steers faults.
*/
module link_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic transceiver_phys_init,
  input wire logic [15:0] ready_delay,
  input wire logic flap,
  input wire logic mismatch_on,
  input wire logic soft_on,
  input wire logic restart_kick,
  output logic channel_ready,
  output logic soft_error,
  output logic link_restart_request,
  output logic [7:0] data_mismatch_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] up_cnt;

  // Cycles since the last physical init; it saturates so a link that has come up stays up.
  always_ff @(posedge aclk) begin
    if (!aresetn || transceiver_phys_init) begin
      up_cnt <= 16'h0000;
    end else if (up_cnt != 16'hffff) begin
      up_cnt <= up_cnt + 16'h0001;
    end
  end

  // ready after init
  // Ready is low through init and returns only after the training delay.
  always_ff @(posedge aclk) begin
    channel_ready <= aresetn && !transceiver_phys_init && (up_cnt >= ready_delay) &&
      !(flap && (up_cnt >= ready_delay + 16'h0004) && (up_cnt < ready_delay + 16'h0006));
  end

  // mismatch count
  // Errors appear only when a scenario asks for them, like a clean link would.
  always_ff @(posedge aclk) begin
    data_mismatch_count <= mismatch_on ? 8'h01 : 8'h00;
    soft_error <= soft_on && channel_ready;
    link_restart_request <= restart_kick;
  end
endmodule : link_core_model

/* File: tb/tb.sv */
/*
  Self-checking bench of the repeat-reset link tester over AXI4-Lite.
  Assumes the link core model beside it and short hold and window counts.
*/
`include "link_tester_cfg.svh"
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [27:0] HOLD = 28'd20;
  localparam logic [31:0] UNIT = 32'd50;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, phys_q, irq_q;
  logic channel_ready, soft_error, link_restart_request, transceiver_phys_init;
  logic flap, mismatch_on, soft_on, restart_kick;
  logic [7:0] awaddr, araddr, data_mismatch_count;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, bs;
  logic [15:0] ready_delay;
  int fail_count, checked, cyc, fall_cyc, irq_cyc, hi_len, hi_run;

  repeat_reset_link_tester #(.HOLD_CYCLES(HOLD), .WINDOW_UNIT_CYCLES(UNIT)) repeat_reset_link_tester_inst (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .channel_ready, .soft_error, .link_restart_request, .data_mismatch_count,
    .transceiver_phys_init, .irq);

  link_core_model link_core_model_inst (
    .aclk, .aresetn, .transceiver_phys_init, .ready_delay, .flap, .mismatch_on, .soft_on,
    .restart_kick, .channel_ready, .soft_error, .link_restart_request, .data_mismatch_count);

  // Free-running 40 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Timestamps of init pulse length and interrupt latency, in clock cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    phys_q <= transceiver_phys_init;
    irq_q <= irq;
    hi_run <= transceiver_phys_init ? hi_run + 1 : 0;
    if (phys_q && !transceiver_phys_init) begin
      fall_cyc <= cyc;
      hi_len <= hi_run;
    end
    if (!irq_q && irq) begin
      irq_cyc <= cyc;
    end
  end

  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Every wait is bounded; running out is a mismatch and ends the run.
  task automatic guard(input int n);
    if (n >= 40000) begin
      fail_count++;
      complete_run();
    end
  endtask : guard

  // Address and data are offered together; each is dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      bs = bresp;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (arvalid && arready) arvalid <= 1'b0;
      rd = rdata;
      rs = rresp;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : axi_read

  // Clear, start a run and wait for the unmasked interrupt, then fetch status.
  task automatic run(input logic [31:0] clr, input logic [31:0] ctrl);
    int n = 0;
    axi_write(`CTRL_OFFSET, clr);
    axi_write(`INT_STATUS_OFFSET, 32'h7);
    axi_write(`CTRL_OFFSET, ctrl);
    do begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (irq !== 1'b1);
    axi_read(`STATUS_OFFSET);
  endtask : run

  // Main sequence; the link comes up ten cycles after each init, except in the dead-link runs.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {flap, mismatch_on, soft_on, restart_kick} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    ready_delay = 16'h000a;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`STATUS_OFFSET);
    `CHECK(rd, 32'h0)
    axi_read(8'h18);
    `CHECK({rs, rd}, {`RESP_SLVERR, 32'h0})
    axi_write(8'h18, 32'h0);
    `CHECK(bs, `RESP_SLVERR)
    for (int i = 0; i < 16; i++) begin
      axi_write(`CTRL_OFFSET, 32'(i) << 8);
      axi_read(`CTRL_OFFSET);
      `CHECK(rd[11:8], 4'(i))
    end
    // Only byte 0 enabled: the window moves, the iteration select keeps its last code.
    wstrb <= 4'h1;
    axi_write(`CTRL_OFFSET, 32'h00000050);
    `CHECK(bs, `RESP_OKAY)
    wstrb <= 4'hf;
    axi_read(`CTRL_OFFSET);
    `CHECK(rd, 32'h00000f50)
    // A full passing run of ten iterations; the link flips twice per init.
    axi_write(`INT_MASK_OFFSET, 32'h1);
    run(32'h6, 32'h1);
    `CHECK(rd, 32'h000a0001)
    // Init stands through the countdown, its zero cycle and the release cycle.
    `CHECK(hi_len, int'(HOLD) + 2)
    axi_read(`READY_COUNT_OFFSET);
    `CHECK(rd, 32'd20)
    // Restart requests raise, mask and clear their interrupt.
    axi_write(`INT_MASK_OFFSET, 32'h4);
    axi_write(`INT_STATUS_OFFSET, 32'h7);
    repeat (3) begin
      @(posedge aclk);
      restart_kick <= 1'b1;
      @(posedge aclk);
      restart_kick <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    `CHECK(irq, 1'b1)
    axi_read(`RESTART_COUNT_OFFSET);
    `CHECK(rd, 32'd3)
    axi_write(`INT_MASK_OFFSET, 32'h0);
    repeat (2) @(posedge aclk);
    `CHECK(irq, 1'b0)
    axi_write(`INT_STATUS_OFFSET, 32'h4);
    axi_read(`INT_STATUS_OFFSET);
    `CHECK(rd[2], 1'b0)
    axi_write(`CTRL_OFFSET, 32'h4);
    axi_read(`READY_COUNT_OFFSET);
    `CHECK(rd, 32'h0)
    axi_read(`RESTART_COUNT_OFFSET);
    `CHECK(rd, 32'h0)
    axi_write(`CTRL_OFFSET, 32'h2);
    axi_read(`STATUS_OFFSET);
    `CHECK(rd, 32'h0)
    // A dead link fails at the end of each selectable window.
    ready_delay <= 16'hfff0;
    axi_write(`INT_MASK_OFFSET, 32'h2);
    for (int s = 0; s < 8; s++) begin
      run(32'h2, 32'h1 | (32'(s) << 4));
      `CHECK(rd[2:0], 3'b010)
      `CHECK((irq_cyc - fall_cyc) inside {[(s + 1) * int'(UNIT) : (s + 1) * int'(UNIT) + 6]}, 1'b1)
    end
    // Mismatches, soft errors and a flapping channel each stop the run.
    ready_delay <= 16'h000a;
    for (int k = 0; k < 3; k++) begin
      mismatch_on <= (k == 0);
      soft_on <= (k == 1);
      flap <= (k == 2);
      run(32'h2, 32'h1);
      `CHECK({rd[31:16], rd[2:0]}, {16'h0, 3'b010})
    end
    complete_run();
  end
endmodule : tb
